// >>> core/light_sensor_conversion_control.sv
`timescale 1ns/1ps
`default_nettype none
module light_sensor_conversion_control (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  input  wire logic [15:0] visible_i,
  input  wire logic [15:0] infrared_i,
  input  wire logic        int_n_i,
  output logic             int_n_o,
  output logic             int_n_oe_o,
  output logic             irq_o,
  output logic             powered_o
);
  import light_sensor_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_POWER_DOWN = 2'b00,
    ST_START      = 2'b01,
    ST_CONVERT    = 2'b11
  } ctl_type;

  typedef struct packed {
    ctl_type      ctl;
    logic [2:0]   op;
    logic         int_flag;
    logic [1:0]   persist;
    res_type      res;
    logic [1:0]   range;
    logic [15:0]  data;
    logic [15:0]  thr_lo;
    logic [15:0]  thr_hi;
    logic [3:0]   out_cnt;
    logic [IRQ_W-1:0] status;
    logic [IRQ_W-1:0] mask;
    logic [7:0]   rdata;
    logic         int_oe;
    logic         irq;
    logic         powered;
    conv_cmd_type cmd;
  } top_state_type;

  top_state_type st_r;
  top_state_type st_nxt;
  bus_req_type   req;
  conv_res_type  conv;
  logic          tick;
  logic          out_range;
  logic [3:0]    persist_need;
  logic [IRQ_W-1:0] events;
  logic          is_cont;

  // Line level is not read; the pin is output-only from our side
  logic unused_pin;
  assign unused_pin = int_n_i;

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  osc_divider u_div (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .run_i   (st_r.ctl == ST_CONVERT),
    .tick_o  (tick)
  );

  charge_balance_adc u_adc (
    .clock_i    (clock_i),
    .rst_i      (rst_i),
    .tick_i     (tick),
    .cmd_i      (st_r.cmd),
    .visible_i  (visible_i),
    .infrared_i (infrared_i),
    .res_o      (conv)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt       = st_r;
    st_nxt.cmd   = '0;
    st_nxt.rdata = 8'h00;
    events       = '0;
    is_cont      = st_r.op[2];
    out_range    = (conv.count > st_r.thr_hi) ||
                   (conv.count < st_r.thr_lo);
    unique case (st_r.persist)
      2'b00:   persist_need = 4'h1;
      2'b01:   persist_need = 4'h4;
      2'b10:   persist_need = 4'h8;
      default: persist_need = 4'h8;
    endcase

    // Conversion sequencing
    unique case (st_r.ctl)
      ST_POWER_DOWN: begin
      end
      ST_START: begin
        st_nxt.cmd = '{start: 1'b1, infrared: st_r.op[1],
                       res: st_r.res, range: st_r.range};
        st_nxt.ctl = ST_CONVERT;
      end
      ST_CONVERT: begin
        // A done pulse beside a fresh start belongs to the cut conversion
        if (conv.done && !st_r.cmd.start) begin
          st_nxt.data = conv.count;
          events[IRQ_DONE] = 1'b1;
          // Persistence counts whole integration cycles only
          if (out_range) begin
            if (st_r.out_cnt != persist_need) begin
              st_nxt.out_cnt = st_r.out_cnt + 4'h1;
            end
            if (st_r.out_cnt + 4'h1 >= persist_need) begin
              st_nxt.int_flag = 1'b1;
              events[IRQ_THRESH] = 1'b1;
            end
          end else begin
            st_nxt.out_cnt = 4'h0;
          end
          // Interrupt never pauses the sequence
          if (is_cont) begin
            st_nxt.ctl = ST_START;
          end else begin
            st_nxt.ctl = ST_POWER_DOWN;
            st_nxt.op  = OP_POWER_DOWN;
          end
        end
      end
      default: st_nxt.ctl = ST_POWER_DOWN;
    endcase

    // Register writes
    if (req.wr) begin
      unique case (req.addr)
        ADDR_COMMAND_1: begin
          st_nxt.op      = req.wdata[OP_MSB:OP_LSB];
          st_nxt.persist = req.wdata[PRST_MSB:PRST_LSB];
          // Writing zero clears the held flag; a new hit this cycle wins
          if (!req.wdata[INT_BIT] && !events[IRQ_THRESH]) begin
            st_nxt.int_flag = 1'b0;
          end
          st_nxt.out_cnt = 4'h0;
          unique case (req.wdata[OP_MSB:OP_LSB])
            OP_ALS_ONCE, OP_IR_ONCE, OP_ALS_CONT, OP_IR_CONT:
              st_nxt.ctl = ST_START;
            default: st_nxt.ctl = ST_POWER_DOWN;
          endcase
        end
        ADDR_COMMAND_2: begin
          st_nxt.res   = res_type'(req.wdata[RES_MSB:RES_LSB]);
          st_nxt.range = req.wdata[RANGE_MSB:RANGE_LSB];
        end
        ADDR_THRESH_LO_L: st_nxt.thr_lo[7:0]  = req.wdata;
        ADDR_THRESH_LO_H: st_nxt.thr_lo[15:8] = req.wdata;
        ADDR_THRESH_HI_L: st_nxt.thr_hi[7:0]  = req.wdata;
        ADDR_THRESH_HI_H: st_nxt.thr_hi[15:8] = req.wdata;
        ADDR_IRQ_STATUS:
          st_nxt.status = st_r.status & ~req.wdata[IRQ_W-1:0];
        ADDR_IRQ_MASK:    st_nxt.mask = req.wdata[IRQ_W-1:0];
        default: begin
        end
      endcase
    end
    // Set beats the write-one clear
    st_nxt.status = st_nxt.status | events;

    // Register reads, data one cycle later
    if (req.rd) begin
      unique case (req.addr)
        ADDR_COMMAND_1:
          st_nxt.rdata = {st_r.op, 2'b00, st_r.int_flag, st_r.persist};
        ADDR_COMMAND_2:
          st_nxt.rdata = {4'h0, st_r.res, st_r.range};
        ADDR_DATA_LSB:    st_nxt.rdata = st_r.data[7:0];
        ADDR_DATA_MSB:    st_nxt.rdata = st_r.data[15:8];
        ADDR_THRESH_LO_L: st_nxt.rdata = st_r.thr_lo[7:0];
        ADDR_THRESH_LO_H: st_nxt.rdata = st_r.thr_lo[15:8];
        ADDR_THRESH_HI_L: st_nxt.rdata = st_r.thr_hi[7:0];
        ADDR_THRESH_HI_H: st_nxt.rdata = st_r.thr_hi[15:8];
        ADDR_IRQ_STATUS:  st_nxt.rdata = {6'h00, st_r.status};
        ADDR_IRQ_MASK:    st_nxt.rdata = {6'h00, st_r.mask};
        default:          st_nxt.rdata = 8'h00;
      endcase
    end

    st_nxt.int_oe  = st_nxt.int_flag;
    st_nxt.irq     = |(st_nxt.status & st_nxt.mask);
    st_nxt.powered = (st_nxt.ctl != ST_POWER_DOWN);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_r        <= '0;
      st_r.thr_hi <= RESET_HI_THR;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o    = st_r.rdata;
  assign int_n_o    = 1'b0;
  assign int_n_oe_o = st_r.int_oe;
  assign irq_o      = st_r.irq;
  assign powered_o  = st_r.powered;
endmodule : light_sensor_conversion_control
`default_nettype wire

// >>> core/light_sensor_pkg.sv
// Contract
// - Integrating converter yields up to 16-bit count
// - Conversion length from 4/8/12/16-bit counter
// - Host selects range, range 0 lowest
// - Start powered down, results zero
// - One-shot converts once then powers down
// - Continuous mode overwrites results each conversion
// - Power-down command stops converting
// - Four modes: one-shot/continuous, visible/infrared
// - Result width equals selected resolution
// - Interrupt pin active low, open drain
// - Flag when above upper or below lower
// - Conversions continue after interrupt asserted
// - Persistence filter up to 8 cycles
package light_sensor_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_COMMAND_1    = 8'h00;
  localparam logic [7:0] ADDR_COMMAND_2    = 8'h01;
  localparam logic [7:0] ADDR_DATA_LSB     = 8'h02;
  localparam logic [7:0] ADDR_DATA_MSB     = 8'h03;
  localparam logic [7:0] ADDR_THRESH_LO_L  = 8'h04;
  localparam logic [7:0] ADDR_THRESH_LO_H  = 8'h05;
  localparam logic [7:0] ADDR_THRESH_HI_L  = 8'h06;
  localparam logic [7:0] ADDR_THRESH_HI_H  = 8'h07;
  localparam logic [7:0] ADDR_IRQ_STATUS   = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK     = 8'h09;

  // Command-1 fields
  localparam int OP_MSB     = 7;
  localparam int OP_LSB     = 5;
  localparam int INT_BIT    = 2;
  localparam int PRST_MSB   = 1;
  localparam int PRST_LSB   = 0;
  // Command-2 fields
  localparam int RES_MSB    = 3;
  localparam int RES_LSB    = 2;
  localparam int RANGE_MSB  = 1;
  localparam int RANGE_LSB  = 0;

  localparam logic [7:0]  RESET_BYTE   = 8'h00;
  localparam logic [15:0] RESET_WORD   = 16'h0000;
  localparam logic [15:0] RESET_HI_THR = 16'hFFFF;

  // Status / mask bit positions
  localparam int IRQ_THRESH = 0;
  localparam int IRQ_DONE   = 1;
  localparam int IRQ_W      = 2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLOCK_MHZ       = 125;
  localparam int OSC_PERIOD_NS   = 40;
  localparam int OSC_DIV         = (OSC_PERIOD_NS * CLOCK_MHZ + 999) / 1000;
  localparam int RES_W           = 16;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_POWER_DOWN = 3'b000,
    OP_ALS_ONCE   = 3'b001,
    OP_IR_ONCE    = 3'b010,
    OP_ALS_CONT   = 3'b101,
    OP_IR_CONT    = 3'b110
  } op_type;

  typedef enum logic [1:0] {
    RES_16 = 2'b00,
    RES_12 = 2'b01,
    RES_8  = 2'b10,
    RES_4  = 2'b11
  } res_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_type;

  typedef struct packed {
    logic       start;
    logic       infrared;
    res_type    res;
    logic [1:0] range;
  } conv_cmd_type;

  typedef struct packed {
    logic        done;
    logic [15:0] count;
  } conv_res_type;

endpackage : light_sensor_pkg

// >>> core/osc_divider.sv
`timescale 1ns/1ps
`default_nettype none
module osc_divider (
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic run_i,
  output logic      tick_o
);
  import light_sensor_pkg::*;

  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } div_state_type;

  div_state_type st_r;
  div_state_type st_nxt;

  // ----------------------------------------------------------------
  // Oscillator tick, stopped in power-down to save energy
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (!run_i) begin
      st_nxt.cnt = 8'h00;
    end else if (st_r.cnt == 8'(OSC_DIV - 1)) begin
      st_nxt.cnt  = 8'h00;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 8'h01;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick_o = st_r.tick;
endmodule : osc_divider
`default_nettype wire

// >>> core/charge_balance_adc.sv
`timescale 1ns/1ps
`default_nettype none
module charge_balance_adc (
  input  wire logic                           clock_i,
  input  wire logic                           rst_i,
  input  wire logic                           tick_i,
  input  wire light_sensor_pkg::conv_cmd_type cmd_i,
  input  wire logic [15:0]                    visible_i,
  input  wire logic [15:0]                    infrared_i,
  output light_sensor_pkg::conv_res_type      res_o
);
  import light_sensor_pkg::*;

  typedef struct packed {
    logic         busy;
    logic         infrared;
    logic [1:0]   range;
    logic [15:0]  last;
    logic [15:0]  accum;
    logic [16:0]  integ;
    logic [15:0]  count;
    conv_res_type res;
  } adc_state_type;

  adc_state_type st_r;
  adc_state_type st_nxt;
  logic [15:0]   src;
  logic [16:0]   scaled;

  // ----------------------------------------------------------------
  // Integration: each tick adds scaled current; overflow emits a count
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt       = st_r;
    st_nxt.res.done = 1'b0;
    src    = st_r.infrared ? infrared_i : visible_i;
    // Higher range divides the current so the same count means more light
    scaled = {1'b0, src >> {st_r.range, 1'b0}};
    if (cmd_i.start) begin
      st_nxt.busy     = 1'b1;
      st_nxt.infrared = cmd_i.infrared;
      st_nxt.range    = cmd_i.range;
      st_nxt.integ    = 17'h0_0000;
      st_nxt.count    = 16'h0000;
      // A restart may cut a conversion short, so the length count starts over
      st_nxt.accum    = 16'h0000;
      unique case (cmd_i.res)
        RES_16: st_nxt.last = 16'hFFFF;
        RES_12: st_nxt.last = 16'h0FFF;
        RES_8:  st_nxt.last = 16'h00FF;
        RES_4:  st_nxt.last = 16'h000F;
      endcase
    end else if (st_r.busy && tick_i) begin
      // Charge balance: subtract a reference packet on each overflow
      st_nxt.integ = st_r.integ + scaled;
      if (st_nxt.integ[16]) begin
        st_nxt.integ[16] = 1'b0;
        if (st_r.count != st_r.last) begin
          st_nxt.count = st_r.count + 16'h0001;
        end
      end
      st_nxt.accum = st_r.accum + 16'h0001;
      if (st_r.accum == st_r.last) begin
        st_nxt.busy      = 1'b0;
        st_nxt.accum     = 16'h0000;
        st_nxt.res.done  = 1'b1;
        st_nxt.res.count = st_nxt.count & st_r.last;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign res_o = st_r.res;
endmodule : charge_balance_adc
`default_nettype wire

// >>> verification/int_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module int_line_model (
  input  wire logic int_n_o,
  input  wire logic int_n_oe_o,
  output logic      line_o
);
  // Pull-up holds the line high whenever the device lets go of it
  assign line_o = int_n_oe_o ? int_n_o : 1'b1;
endmodule : int_line_model
`default_nettype wire

// >>> verification/light_sensor_checker.sv
`timescale 1ns/1ps
`default_nettype none
module light_sensor_checker (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic [7:0] rdata_o,
  input  wire logic       int_n_o,
  input  wire logic       int_n_oe_o,
  input  wire logic       irq_o,
  input  wire logic       powered_o
);
  import light_sensor_pkg::*;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic c1w;
  assign c1w = wr_i && addr_i == ADDR_COMMAND_1;
  pin_low_a: assert property (int_n_o == 1'b0)
    else $error("interrupt pin driven high");
  rst_quiet_a: assert property ($fell(rst_i) |->
    !powered_o && !int_n_oe_o && !irq_o && rdata_o == 8'h00)
    else $error("outputs active after reset");
  stop_cmd_a: assert property (c1w && wdata_i[7:5] == 3'b000
    |=> !powered_o) else $error("still powered after stop");
  start_cmd_a: assert property (c1w && wdata_i[7:5] inside
    {3'b001, 3'b010, 3'b101, 3'b110} |-> ##[1:3] powered_o)
    else $error("mode command did not start");
  flag_hold_a: assert property (int_n_oe_o && !c1w |=> int_n_oe_o)
    else $error("interrupt dropped without clear");
  // A hit in the clearing cycle wins, so only idle clears must drop it
  flag_clear_a: assert property (c1w && !powered_o &&
    wdata_i == 8'h00 |=> !int_n_oe_o) else $error("interrupt not cleared");
  mask_off_a: assert property (wr_i && addr_i == ADDR_IRQ_MASK &&
    wdata_i[1:0] == 2'b00 |=> ##1 !irq_o) else $error("masked irq high");
  idle_rdata_a: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data without read");
  cover property ($rose(int_n_oe_o));
  cover property ($fell(powered_o) && !c1w);
  cover property (c1w ##1 powered_o);
endmodule : light_sensor_checker
bind light_sensor_conversion_control light_sensor_checker u_chk (
  .clock_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
  .int_n_o, .int_n_oe_o, .irq_o, .powered_o);
`default_nettype wire

// >>> verification/light_sensor_conversion_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module light_sensor_conversion_control_tb;
  import light_sensor_pkg::*;
  logic        clock_i    = 1'b0;
  logic        rst_i      = 1'b1;
  logic [7:0]  addr_i     = 8'h00;
  logic [7:0]  wdata_i    = 8'h00;
  logic        wr_i       = 1'b0;
  logic        rd_i       = 1'b0;
  logic [15:0] visible_i  = 16'h0000;
  logic [15:0] infrared_i = 16'h0000;
  logic [7:0]  rdata_o, b;
  logic [15:0] v;
  logic        int_n_o, int_n_oe_o, irq_o, powered_o, line;
  int          num_errors = 0;
  int          tests_run  = 0;
  int          cyc, cyc4, need;
  integer      seed       = 45476;
  integer      k;
  logic [7:0]  rst_val [0:10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                  8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};

  light_sensor_conversion_control dut (.clock_i, .rst_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .visible_i, .infrared_i, .int_n_i(line),
    .int_n_o, .int_n_oe_o, .irq_o, .powered_o);
  int_line_model pin (.int_n_o, .int_n_oe_o, .line_o(line));

  always #4 clock_i = ~clock_i;

  task automatic chk(input string what, input logic [15:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, d);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clock_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
  endtask : rd

  task automatic rd16(input logic [7:0] a, output logic [15:0] d);
    rd(a, d[7:0]);
    rd(a + 8'h01, d[15:8]);
  endtask : rd16

  // Polls the done bit; cycle count is coarse since a read costs two
  task automatic wait_done(output int n);
    logic [7:0] s;
    n = 0;
    s = 8'h00;
    while (s[IRQ_DONE] !== 1'b1 && n < 4000) begin
      rd(ADDR_IRQ_STATUS, s);
      n += 2;
    end
    chk("done bit", 16'h0001, 16'(s[IRQ_DONE]));
    wr(ADDR_IRQ_STATUS, 8'h02);
  endtask : wait_done

  function automatic logic [15:0] expect_count(input logic [15:0] s,
                                               input int rng, n);
    logic [47:0] t;
    t = ((48'(s) >> (2 * rng)) << n) >> 16;
    if (t > (48'h1 << n) - 48'h1) t = (48'h1 << n) - 48'h1;
    return t[15:0];
  endfunction : expect_count

  task automatic shot(input logic [7:0] c2, c1, input logic [15:0] s,
                      input int rng, n);
    @(posedge clock_i);
    visible_i  <= s;
    infrared_i <= s >> 2;
    wr(ADDR_COMMAND_2, c2);
    wr(ADDR_COMMAND_1, c1);
    wait_done(cyc);
    rd16(ADDR_DATA_LSB, v);
    chk("result", expect_count(c1[6] ? s >> 2 : s, rng, n), v);
    repeat (40) @(posedge clock_i);
    v = 16'h0000;
    rd16(ADDR_DATA_LSB, v);
    chk("kept", expect_count(c1[6] ? s >> 2 : s, rng, n), v);
    chk("auto off", 16'h0000, 16'(powered_o));
    rd(ADDR_COMMAND_1, b);
    chk("op back", 16'h0000, 16'(b));
  endtask : shot

  task automatic end_sim;
    if (num_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim

  initial begin
    repeat (30000) @(posedge clock_i);
    num_errors++;
    end_sim;
  end

  initial begin
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    wr(8'h0A, 8'hFF);
    for (int a = 0; a <= 10; a++) begin
      rd(8'(a), b);
      chk("reset value", 16'(rst_val[a]), 16'(b));
    end
    chk("pin idle", 16'h0001, 16'(line));
    shot(8'h0C, 8'h20, 16'hC000, 0, 4);
    shot(8'h0C, 8'h40, 16'hC000, 0, 4);
    shot(8'h0D, 8'h20, 16'hC000, 1, 4);
    shot(8'h0C, 8'h20, 16'hFFFF, 0, 4);
    cyc4 = cyc;
    chk("short conv", 16'h0001, 16'(cyc4 >= 14 * OSC_DIV &&
        cyc4 <= 18 * OSC_DIV));
    shot(8'h08, 8'h20, 16'hFFFF, 0, 8);
    chk("long conv", 16'h0001, 16'(cyc > 12 * cyc4));
    wr(ADDR_COMMAND_2, 8'h0C);
    for (int i = 0; i < 6; i++) begin
      k = $random(seed);
      @(posedge clock_i);
      visible_i  <= {k[3:0], 12'h000};
      infrared_i <= {k[7:4], 12'h000};
      wr(ADDR_COMMAND_1, i[0] ? 8'hC0 : 8'hA0);
      repeat (2) wait_done(cyc);
      rd16(ADDR_DATA_LSB, v);
      chk("newest", expect_count(i[0] ? infrared_i : visible_i, 0, 4),
          v);
      chk("running", 16'h0001, 16'(powered_o));
    end
    wr(ADDR_COMMAND_1, 8'h00);
    wr(ADDR_IRQ_STATUS, 8'h03);
    chk("stopped", 16'h0000, 16'(powered_o));
    repeat (200) @(posedge clock_i);
    rd(ADDR_IRQ_STATUS, b);
    chk("no conv", 16'h0000, 16'(b));
    wr(ADDR_THRESH_LO_L, 8'h02);
    wr(ADDR_THRESH_HI_L, 8'h08);
    wr(ADDR_THRESH_HI_H, 8'h00);
    wr(ADDR_IRQ_MASK, 8'h03);
    // Odd codes test the lower bound, even codes the upper one
    for (int p = 0; p < 4; p++) begin
      @(posedge clock_i);
      visible_i <= p[0] ? 16'h1000 : 16'hC000;
      wr(ADDR_COMMAND_1, 8'hA0 | 8'(p));
      need = (p == 0) ? 1 : (p == 1) ? 4 : 8;
      for (int j = 1; j <= need; j++) begin
        wait_done(cyc);
        chk("pin", 16'(j != need), 16'(line));
      end
      chk("irq", 16'h0001, 16'(irq_o));
      wait_done(cyc);
      chk("pin held", 16'h0000, 16'(line));
      wr(ADDR_IRQ_MASK, 8'h00);
      @(posedge clock_i);
      #1 chk("masked", 16'h0000, 16'(irq_o));
      wr(ADDR_IRQ_MASK, 8'h03);
      // Stop first so that no threshold hit can fall on the clear
      wr(ADDR_COMMAND_1, 8'h04);
      @(posedge clock_i);
      #1 chk("pin kept", 16'h0000, 16'(line));
      wr(ADDR_COMMAND_1, 8'h00);
      @(posedge clock_i);
      #1 chk("pin freed", 16'h0001, 16'(line));
      wr(ADDR_IRQ_STATUS, 8'h03);
      @(posedge clock_i);
      #1 chk("irq clear", 16'h0000, 16'(irq_o));
    end
    end_sim;
  end
endmodule : light_sensor_conversion_control_tb
`default_nettype wire
